// >>> pwt_pkg.sv
/*
 * Constants shared by the three-channel PWM/timer control block: register
 * offsets, field positions, reset values and counter limits.
 * Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
 */
// Operation
// [R1] Channel 0 prescaler input is the internal clock or the external count clock pin.
// [R2] Stop source raises the channel interrupt whenever the channel halts.
// [R3] First edge source interrupts when a count starts and at end of count.
// [R4] Second edge source interrupts at the half-count point of the cycle.
// [R5] Both edge sources together interrupt on every output waveform transition; the code raises none when the output drops at stop or at reset.
// [R6] Stop source excludes edge sources; with nothing chosen, stop is used.
// [R7] Channel 0 start/stop and set/reset come from firmware, pins, or both.
// [R8] Pin controls may be edge or level; firmware controls are level only.
// [R9] Edge mode toggles the controlled state on each rising pin edge.
// [R10] Level mode follows the present level of the control signal.
// [R11] Channels 1 and 2 use internal clock and firmware controls only.
// [R12] Firmware gives only start and reset to a channel in PWM mode; the code does not block stop or set there.
// [R13] One simultaneous-start write starts two or three channels together.
// [R14] Channel 0 with pin controls skips simultaneous start; both pins block firmware.
// [R15] PWM counts reload up to 255; duty comes from the counter register.
// [R16] Prescaler divides by a power of two, at most 65536.
// [R17] Timer output is a 50% square wave or a one-tick pulse.
// [R18] Pin inputs pass two synchroniser flops before sampling or edge detection.
// [R19] Interrupt flags stay pending until cleared and are masked after reset.
package pwt_pkg;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam logic [7:0] PWT_OFS_CFG0     = 8'h00;
	localparam logic [7:0] PWT_OFS_CFG1     = 8'h04;
	localparam logic [7:0] PWT_OFS_CFG2     = 8'h08;
	localparam logic [7:0] PWT_OFS_VAL0     = 8'h10;
	localparam logic [7:0] PWT_OFS_VAL1     = 8'h14;
	localparam logic [7:0] PWT_OFS_VAL2     = 8'h18;
	localparam logic [7:0] PWT_OFS_CTRL     = 8'h24;
	localparam logic [7:0] PWT_OFS_SIMUL    = 8'h28;
	localparam logic [7:0] PWT_OFS_IRQ_STAT = 8'h2c;
	localparam logic [7:0] PWT_OFS_IRQ_MASK = 8'h30;
	localparam logic [7:0] PWT_OFS_STATUS   = 8'h34;

	// ==========================================================================
	// Channel configuration fields
	// ==========================================================================
	localparam int PWT_CFG_MODE_PWM   = 0;
	localparam int PWT_CFG_WAVE_PULSE = 1;
	localparam int PWT_CFG_SRC_STOP   = 2;
	localparam int PWT_CFG_SRC_RISE   = 3;
	localparam int PWT_CFG_SRC_FALL   = 4;
	localparam int PWT_CFG_CLK_EXT    = 5;
	localparam int PWT_CFG_SS_INT     = 6;
	localparam int PWT_CFG_SS_EXT     = 7;
	localparam int PWT_CFG_SS_EDGE    = 8;
	localparam int PWT_CFG_RS_INT     = 9;
	localparam int PWT_CFG_RS_EXT     = 10;
	localparam int PWT_CFG_RS_EDGE    = 11;
	localparam int PWT_CFG_PRESC_LSB  = 12;
	localparam int PWT_CFG_WIDTH      = 17;
	localparam int PWT_EXT_MSB        = 11;

	// ==========================================================================
	// Reset values and counter limits
	// ==========================================================================
	localparam logic [16:0] PWT_CFG_RST = 17'h00244;
	localparam logic [15:0] PWT_VAL_RST = 16'h0000;
	localparam logic [7:0]  PWT_CNT_TOP = 8'hff;
	localparam logic [4:0]  PWT_PRESC_MAX = 5'h10;
	localparam int          PWT_PRESC_W   = 17;
	localparam logic [1:0]  PWT_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  PWT_RESP_SLVERR = 2'b10;

	// Channel sequencer states.
	typedef enum logic [1:0] {
		PWT_IDLE = 2'b01,
		PWT_RUN  = 2'b10
	} pwt_state_e;

endpackage

// >>> pwt_chan.sv
/*
 * One PWM/timer channel: power-of-two prescaler, 8-bit counter, output
 * waveform and the start, half-count, end and stop events.
 * Assumes run and reset levels already resolved and synchronous to aclk.
 */
`timescale 1ns/1ns
`default_nettype none
module pwt_chan
	import pwt_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_tick,
	input  wire logic [4:0]       presc_exp,
	input  wire logic             run,
	input  wire logic             rst,
	input  wire logic             mode_pwm,
	input  wire logic             wave_pulse,
	input  wire logic [CNT_W-1:0] reload,
	input  wire logic [CNT_W-1:0] value,
	output logic                  wave,
	output logic                  running,
	output logic                  ev_start,
	output logic                  ev_half,
	output logic                  ev_end,
	output logic                  ev_stop
);
	// ==========================================================================
	// Prescaler and counter
	// ==========================================================================
	pwt_state_e            state_ff, nxt_state;
	logic [PWT_PRESC_W-1:0] pcnt_ff, nxt_pcnt;
	logic [CNT_W-1:0]      cnt_ff, nxt_cnt;
	logic                  wave_ff, nxt_wave;
	logic [4:0]            exp_c;
	logic [PWT_PRESC_W-1:0] pdiv;
	logic                  tick;
	logic [CNT_W-1:0]      top;

	// Division factor saturates at 2^16 so a wild setting cannot stall the channel.
	assign exp_c = (presc_exp > PWT_PRESC_MAX) ? PWT_PRESC_MAX : presc_exp; // [R16]
	assign pdiv  = (PWT_PRESC_W'(1) << exp_c) - PWT_PRESC_W'(1);
	assign tick  = in_tick && (pcnt_ff == pdiv);
	// A zero timer value acts as one so the period never collapses.
	assign top   = (value == '0) ? '0 : value - CNT_W'(1);

	// Next-state logic; reset holds the counter at its load point, output low.
	always_comb begin
		nxt_state = state_ff;
		nxt_pcnt  = pcnt_ff;
		nxt_cnt   = cnt_ff;
		nxt_wave  = wave_ff;
		ev_start  = 1'b0;
		ev_half   = 1'b0;
		ev_end    = 1'b0;
		ev_stop   = 1'b0;
		if (in_tick) begin
			nxt_pcnt = tick ? '0 : pcnt_ff + PWT_PRESC_W'(1);
		end
		case (state_ff)
			PWT_IDLE: begin
				nxt_pcnt = '0;
				if (run && !rst) begin
					nxt_state = PWT_RUN;
					nxt_cnt   = mode_pwm ? reload : '0;
					nxt_wave  = 1'b1;
					ev_start  = 1'b1; // [R3]
				end
			end
			PWT_RUN: begin
				if (!run) begin
					nxt_state = PWT_IDLE;
					nxt_wave  = 1'b0;
					ev_stop   = 1'b1; // [R2]
				end else if (rst) begin
					nxt_cnt  = mode_pwm ? reload : '0;
					nxt_pcnt = '0;
					nxt_wave = 1'b0;
				end else if (tick && mode_pwm) begin
					// Period runs reload..255; output drops when the count meets the duty.
					if (cnt_ff == PWT_CNT_TOP) begin // [R15]
						nxt_cnt  = reload;
						nxt_wave = 1'b1;
						ev_end   = 1'b1; // [R3]
						ev_start = 1'b1;
					end else begin
						nxt_cnt = cnt_ff + CNT_W'(1);
						if (nxt_cnt == value && wave_ff) begin
							nxt_wave = 1'b0;
							ev_half  = 1'b1; // [R4]
						end
					end
				end else if (tick) begin
					// Timer: square toggles every period, pulse lasts one prescaled tick.
					if (cnt_ff >= top) begin // [R17]
						nxt_cnt  = '0;
						nxt_wave = wave_pulse ? 1'b1 : !wave_ff;
						ev_end   = nxt_wave && !wave_ff;
						ev_half  = wave_ff && !nxt_wave;
					end else begin
						nxt_cnt  = cnt_ff + CNT_W'(1);
						nxt_wave = wave_pulse ? 1'b0 : wave_ff;
						ev_half  = wave_pulse && wave_ff;
					end
				end
			end
			default: begin
				nxt_state = PWT_IDLE;
			end
		endcase
	end

	// Registers of the channel.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= PWT_IDLE;
			pcnt_ff  <= '0;
			cnt_ff   <= '0;
			wave_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pcnt_ff  <= nxt_pcnt;
			cnt_ff   <= nxt_cnt;
			wave_ff  <= nxt_wave;
		end
	end

	assign wave    = wave_ff;
	assign running = (state_ff == PWT_RUN);

endmodule
`default_nettype wire

// >>> pwt_top.sv
/*
 * Three-channel PWM/timer control with an AXI4-Lite register slave,
 * pin control for channel 0 and a masked, sticky interrupt.
 * Assumes pins are synchronous-safe after two flops and one 100 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module pwt_top
	import pwt_pkg::*;
#(
	parameter int NCH = 3
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         ext_count_clock_pin,
	input  wire logic         ext_start_stop_pin,
	input  wire logic         ext_set_reset_pin,
	output logic [NCH-1:0]    timer_output_wave,
	output logic              irq
);
	// Byte-lane merge of a write into an existing register value.
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
	                                       input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================================
	// Pin synchronisers and edge detection
	// ==========================================================================
	logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
	logic       clk_rise, ss_rise, rs_rise;

	// The first stage feeds only the second; edges are taken from stages two and three.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_s3_ff <= '0;
		end else begin
			pin_s1_ff <= {ext_set_reset_pin, ext_start_stop_pin, ext_count_clock_pin}; // [R18]
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end
	assign clk_rise = pin_s2_ff[0] && !pin_s3_ff[0];
	assign ss_rise  = pin_s2_ff[1] && !pin_s3_ff[1];
	assign rs_rise  = pin_s2_ff[2] && !pin_s3_ff[2];

	// ==========================================================================
	// Register state
	// ==========================================================================
	logic [PWT_CFG_WIDTH-1:0] cfg_ff [NCH];
	logic [PWT_CFG_WIDTH-1:0] nxt_cfg [NCH];
	logic [15:0]              val_ff [NCH];
	logic [15:0]              nxt_val [NCH];
	logic [NCH-1:0] sw_run_ff, nxt_sw_run, sw_rst_ff, nxt_sw_rst;
	logic [NCH-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
	logic           ss_tog_ff, nxt_ss_tog, rs_tog_ff, nxt_rs_tog;
	logic           irq_ff, nxt_irq;
	logic [NCH-1:0] wave_ff;
	logic [NCH-1:0] ch_run, ch_rst, ch_tick, running, ch_event;
	logic [NCH-1:0] ev_start, ev_half, ev_end, ev_stop;
	logic           ch0_both_ext, ch0_any_ext, ext_run, ext_rst;

	// ==========================================================================
	// AXI4-Lite slave handshake
	// ==========================================================================
	logic        aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
	logic        awready_ff, nxt_awready, wready_ff, nxt_wready;
	logic        bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
	logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [7:0]  awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic [3:0]  wstrb_ff, nxt_wstrb;
	logic        do_wr;

	// Address and data are latched independently; the write lands once both are held.
	always_comb begin
		nxt_aw_have = aw_have_ff;
		nxt_w_have  = w_have_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_have = 1'b1;
			nxt_awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_have = 1'b1;
			nxt_wdata  = s_axi_wdata;
			nxt_wstrb  = s_axi_wstrb;
		end
		do_wr = aw_have_ff && w_have_ff && !bvalid_ff;
		if (do_wr) begin
			nxt_aw_have = 1'b0;
			nxt_w_have  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = (awaddr_ff <= PWT_OFS_STATUS && awaddr_ff[1:0] == 2'b00 &&
			               awaddr_ff != 8'h0c && awaddr_ff != 8'h1c && awaddr_ff != 8'h20)
			              ? PWT_RESP_OKAY : PWT_RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		nxt_awready = !nxt_aw_have && !nxt_bvalid;
		nxt_wready  = !nxt_w_have && !nxt_bvalid;
	end

	// Read path: one cycle to take the address, data valid the cycle after.
	always_comb begin
		nxt_arready = arready_ff;
		nxt_rvalid  = rvalid_ff;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (s_axi_arvalid && arready_ff) begin
			nxt_arready = 1'b0;
			nxt_rvalid  = 1'b1;
			nxt_rresp   = PWT_RESP_OKAY;
			case (s_axi_araddr)
				PWT_OFS_CFG0:     nxt_rdata = 32'(cfg_ff[0]);
				PWT_OFS_CFG1:     nxt_rdata = 32'(cfg_ff[1]);
				PWT_OFS_CFG2:     nxt_rdata = 32'(cfg_ff[2]);
				PWT_OFS_VAL0:     nxt_rdata = 32'(val_ff[0]);
				PWT_OFS_VAL1:     nxt_rdata = 32'(val_ff[1]);
				PWT_OFS_VAL2:     nxt_rdata = 32'(val_ff[2]);
				PWT_OFS_CTRL:     nxt_rdata = 32'({sw_rst_ff, sw_run_ff});
				PWT_OFS_SIMUL:    nxt_rdata = 32'h0000_0000;
				PWT_OFS_IRQ_STAT: nxt_rdata = 32'(ist_ff);
				PWT_OFS_IRQ_MASK: nxt_rdata = 32'(imask_ff);
				PWT_OFS_STATUS:   nxt_rdata = 32'({wave_ff, running});
				default: begin
					nxt_rdata = 32'h0000_0000;
					nxt_rresp = PWT_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid  = 1'b0;
			nxt_arready = 1'b1;
		end else if (!rvalid_ff) begin
			nxt_arready = 1'b1;
		end
	end

	// ==========================================================================
	// Channel 0 control resolution
	// ==========================================================================
	assign ch0_both_ext = cfg_ff[0][PWT_CFG_SS_EXT] && cfg_ff[0][PWT_CFG_RS_EXT];
	assign ch0_any_ext  = cfg_ff[0][PWT_CFG_SS_EXT] || cfg_ff[0][PWT_CFG_RS_EXT];

	// Edge mode keeps a toggle per pin; it is cleared whenever edge mode is off.
	always_comb begin
		nxt_ss_tog = cfg_ff[0][PWT_CFG_SS_EDGE] ? (ss_tog_ff ^ ss_rise) : 1'b0; // [R9]
		nxt_rs_tog = cfg_ff[0][PWT_CFG_RS_EDGE] ? (rs_tog_ff ^ rs_rise) : 1'b0; // [R9]
		ext_run = cfg_ff[0][PWT_CFG_SS_EDGE] ? ss_tog_ff : pin_s2_ff[1]; // [R8] [R10]
		ext_rst = cfg_ff[0][PWT_CFG_RS_EDGE] ? rs_tog_ff : pin_s2_ff[2]; // [R10]
	end

	// Firmware levels OR pin levels per enabled source; nothing enabled means firmware.
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			ch_run[c] = sw_run_ff[c];
			ch_rst[c] = sw_rst_ff[c];
			ch_tick[c] = 1'b1; // [R11]
		end
		ch_run[0] = (sw_run_ff[0] && (cfg_ff[0][PWT_CFG_SS_INT] || !cfg_ff[0][PWT_CFG_SS_EXT]))
		          || (cfg_ff[0][PWT_CFG_SS_EXT] && ext_run); // [R7]
		ch_rst[0] = (sw_rst_ff[0] && (cfg_ff[0][PWT_CFG_RS_INT] || !cfg_ff[0][PWT_CFG_RS_EXT]))
		          || (cfg_ff[0][PWT_CFG_RS_EXT] && ext_rst); // [R7]
		ch_tick[0] = cfg_ff[0][PWT_CFG_CLK_EXT] ? clk_rise : 1'b1; // [R1]
	end

	// ==========================================================================
	// Register writes, interrupt flags and mask
	// ==========================================================================
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			nxt_cfg[c] = cfg_ff[c];
			nxt_val[c] = val_ff[c];
		end
		nxt_sw_run = sw_run_ff;
		nxt_sw_rst = sw_rst_ff;
		nxt_imask  = imask_ff;
		nxt_ist    = ist_ff;
		if (do_wr) begin
			for (int c = 0; c < NCH; c++) begin
				if (awaddr_ff == PWT_OFS_CFG0 + 8'(4 * c)) begin
					nxt_cfg[c] = PWT_CFG_WIDTH'(wmerge(32'(cfg_ff[c]), wdata_ff, wstrb_ff));
					if (c != 0) begin
						// No pins reach channels 1 and 2.
						nxt_cfg[c][PWT_EXT_MSB:PWT_CFG_CLK_EXT] = 7'h12; // [R11]
					end
				end
				if (awaddr_ff == PWT_OFS_VAL0 + 8'(4 * c)) begin
					nxt_val[c] = 16'(wmerge(32'(val_ff[c]), wdata_ff, wstrb_ff));
				end
			end
			if (awaddr_ff == PWT_OFS_CTRL && wstrb_ff[0]) begin
				nxt_sw_run = wdata_ff[2:0]; // [R8]
				nxt_sw_rst = wdata_ff[5:3];
				if (ch0_both_ext) begin
					nxt_sw_run[0] = sw_run_ff[0]; // [R14]
					nxt_sw_rst[0] = sw_rst_ff[0];
				end
			end
			if (awaddr_ff == PWT_OFS_SIMUL && wstrb_ff[0]) begin
				// All chosen channels but a pin-controlled channel 0 see run rise on the same edge.
				nxt_sw_run = sw_run_ff | (wdata_ff[2:0] & {2'b11, !ch0_any_ext}); // [R13] [R14]
			end
			if (awaddr_ff == PWT_OFS_IRQ_MASK && wstrb_ff[0]) begin
				nxt_imask = wdata_ff[2:0];
			end
			if (awaddr_ff == PWT_OFS_IRQ_STAT && wstrb_ff[0]) begin
				nxt_ist = ist_ff & ~wdata_ff[2:0];
			end
		end
		// Source select: any edge source overrides stop; none chosen falls back to stop.
		for (int c = 0; c < NCH; c++) begin
			ch_event[c] = ((cfg_ff[c][PWT_CFG_SRC_RISE] || cfg_ff[c][PWT_CFG_SRC_FALL])
			                  ? 1'b0 : ev_stop[c]) // [R6] [R2]
			            || (cfg_ff[c][PWT_CFG_SRC_RISE] && (ev_start[c] || ev_end[c])) // [R3] [R5]
			            || (cfg_ff[c][PWT_CFG_SRC_FALL] && ev_half[c]); // [R4] [R5]
		end
		// A new event in the clearing cycle is kept: set wins over clear.
		nxt_ist = nxt_ist | ch_event; // [R19]
		nxt_irq = |(nxt_ist & imask_ff); // [R19]
	end

	// Register process for control, bus and interrupt state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < NCH; c++) begin
				cfg_ff[c] <= PWT_CFG_RST;
				val_ff[c] <= PWT_VAL_RST;
			end
			sw_run_ff  <= '0;
			sw_rst_ff  <= '0;
			ist_ff     <= '0;
			imask_ff   <= '0;
			ss_tog_ff  <= 1'b0;
			rs_tog_ff  <= 1'b0;
			irq_ff     <= 1'b0;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= PWT_RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= PWT_RESP_OKAY;
			rdata_ff   <= '0;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
		end else begin
			cfg_ff     <= nxt_cfg;
			val_ff     <= nxt_val;
			sw_run_ff  <= nxt_sw_run;
			sw_rst_ff  <= nxt_sw_rst;
			ist_ff     <= nxt_ist;
			imask_ff   <= nxt_imask;
			ss_tog_ff  <= nxt_ss_tog;
			rs_tog_ff  <= nxt_rs_tog;
			irq_ff     <= nxt_irq;
			aw_have_ff <= nxt_aw_have;
			w_have_ff  <= nxt_w_have;
			awready_ff <= nxt_awready;
			wready_ff  <= nxt_wready;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff  <= nxt_rvalid;
			rresp_ff   <= nxt_rresp;
			rdata_ff   <= nxt_rdata;
			awaddr_ff  <= nxt_awaddr;
			wdata_ff   <= nxt_wdata;
			wstrb_ff   <= nxt_wstrb;
		end
	end

	// ==========================================================================
	// Channels
	// ==========================================================================
	// Stop and set are not offered in PWM mode; firmware is trusted to keep to that.
	for (genvar g = 0; g < NCH; g++) begin : gen_ch
		pwt_chan #(.CNT_W(8)) u_chan (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.in_tick    (ch_tick[g]),
			.presc_exp  (cfg_ff[g][PWT_CFG_PRESC_LSB +: 5]),
			.run        (ch_run[g]), // [R12]
			.rst        (ch_rst[g]),
			.mode_pwm   (cfg_ff[g][PWT_CFG_MODE_PWM]),
			.wave_pulse (cfg_ff[g][PWT_CFG_WAVE_PULSE]),
			.reload     (val_ff[g][15:8]),
			.value      (val_ff[g][7:0]),
			.wave       (wave_ff[g]),
			.running    (running[g]),
			.ev_start   (ev_start[g]),
			.ev_half    (ev_half[g]),
			.ev_end     (ev_end[g]),
			.ev_stop    (ev_stop[g])
		);
	end

	assign timer_output_wave = wave_ff;
	assign irq               = irq_ff;
	assign s_axi_awready     = awready_ff;
	assign s_axi_wready      = wready_ff;
	assign s_axi_bvalid      = bvalid_ff;
	assign s_axi_bresp       = bresp_ff;
	assign s_axi_arready     = arready_ff;
	assign s_axi_rvalid      = rvalid_ff;
	assign s_axi_rresp       = rresp_ff;
	assign s_axi_rdata       = rdata_ff;

endmodule
`default_nettype wire

// >>> pwt_properties.sv
/* Bus and interrupt checker for the PWM/timer block, bound to its top.
   Assumes one clock domain and the register map of pwt_pkg. */
`timescale 1ns/1ns
`default_nettype none
module pwt_props
	import pwt_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        irq
);
	// =====
	// Properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A write pair or a read address taken at one edge.
	sequence wr_at(logic [7:0] a);
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == a;
	endsequence
	sequence rd_at(logic [7:0] a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence
	// Reset is checked itself, so this one ignores the default disable.
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");
	a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during response");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_wr_answer: assert property (wr_at(PWT_OFS_CTRL) |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == PWT_RESP_OKAY))
		else $error("mapped write not answered okay");
	a_unmapped_wr: assert property (wr_at(8'h0c) |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == PWT_RESP_SLVERR))
		else $error("unmapped write not refused");
	a_unmapped_rd: assert property (rd_at(8'h0c) |=> s_axi_rresp == PWT_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule
bind pwt_top pwt_props pwt_props_inst (.*);
`default_nettype wire

// >>> pwt_pins.sv
/* Model of the channel 0 pin drivers: a free count clock and start/reset levels.
   Assumes the bench calls drive_ss right after a rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
module pwt_pins (
	input  wire logic aclk,
	output logic      ext_count_clock_pin,
	output logic      ext_start_stop_pin,
	output logic      ext_set_reset_pin
);
	logic [1:0] div_ff = 2'h0;
	// Count clock at a quarter of aclk; the reset pin stays inactive.
	always @(posedge aclk) div_ff <= div_ff + 2'h1;
	assign ext_count_clock_pin = div_ff[1];
	assign ext_set_reset_pin = 1'b0;
	initial ext_start_stop_pin = 1'b0;
	// Each level is held four cycles so the two-flop synchroniser sees it.
	task automatic drive_ss(input logic v);
		ext_start_stop_pin <= v;
		repeat (4) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
/* Self-checking bench: register rows, then interrupts, simultaneous start
   and channel 0 pin control. Assumes pwt_pins as the pin driver. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pwt_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} pwt_row_s;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, irq, ext_count_clock_pin, ext_start_stop_pin, ext_set_reset_pin;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  timer_output_wave;
	int          error_cnt = 0, tests_run = 0;
	// Register rows: written value and expected read-back.
	pwt_row_s rows [6] = '{
		'{PWT_OFS_CFG0, 32'h10244, 32'h10244},
		'{PWT_OFS_CFG1, 32'h00fff, 32'h0025f},
		'{PWT_OFS_CFG2, 32'h00018, 32'h00258},
		'{PWT_OFS_VAL0, 32'h0ab12, 32'h0ab12},
		'{PWT_OFS_IRQ_MASK, 32'h7, 32'h7},
		'{8'h0c, 32'h1, 32'h0}};
	always #5 aclk = ~aclk;
	pwt_top pwt_top_inst (.*);
	pwt_pins pwt_pins_inst (.*);
	// =====
	// Reporting
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// =====
	// Bus master; each handshake wait is bounded and a lapse ends the run.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic b;
		b = 0;
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		for (n = 0; n < 40 && !b; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 0; b = 1; rs = s_axi_bresp;
			end
		end
		if (!b) begin
			error_cnt++; results;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		logic g;
		g = 0;
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		for (n = 0; n < 40 && !g; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 0; g = 1; v = s_axi_rdata; rs = s_axi_rresp;
			end
		end
		if (!g) begin
			error_cnt++; results;
		end
	endtask
	// Reads until the masked field settles; pins lag by the synchroniser.
	task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		for (int n = 0; n < 30; n++) begin
			rd(a, d, r);
			if ((d & m) === e) break;
		end
		chk(nm, d & m, e);
	endtask
	// =====
	// Main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rd(PWT_OFS_CFG0, d, r); chk("cfg0 reset", d, 32'h244);
		rd(PWT_OFS_IRQ_MASK, d, r); chk("mask reset", d, 32'h0);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i].a, rows[i].w, r);
			rd(rows[i].a, d, r);
			chk("row", d, rows[i].e);
		end
		chk("unmapped resp", r, PWT_RESP_SLVERR);
		// Stop source on channel 1: silent at start, flag at stop, cleared by one.
		wr(PWT_OFS_CFG1, 32'h244, r);
		wr(PWT_OFS_CTRL, 32'h2, r);
		poll("run1", PWT_OFS_STATUS, 32'h7, 32'h2);
		rd(PWT_OFS_IRQ_STAT, d, r); chk("no start irq", d, 32'h0);
		wr(PWT_OFS_CTRL, 32'h0, r);
		poll("stop irq", PWT_OFS_IRQ_STAT, 32'h7, 32'h2);
		chk("irq high", irq, 1'b1);
		wr(PWT_OFS_IRQ_STAT, 32'h2, r);
		rd(PWT_OFS_IRQ_STAT, d, r); chk("w1c", d, 32'h0);
		chk("irq low", irq, 1'b0);
		// Edge sources on channel 2 flag the start of a count.
		wr(PWT_OFS_CTRL, 32'h4, r);
		poll("start irq", PWT_OFS_IRQ_STAT, 32'h4, 32'h4);
		wr(PWT_OFS_CTRL, 32'h0, r);
		// Channel 0 on its pin must stay out of the simultaneous start.
		wr(PWT_OFS_CFG0, 32'h2c4, r);
		wr(PWT_OFS_SIMUL, 32'h7, r);
		poll("simul", PWT_OFS_STATUS, 32'h7, 32'h6);
		wr(PWT_OFS_CTRL, 32'h0, r);
		wr(PWT_OFS_IRQ_STAT, 32'h7, r);
		// Pin in level mode, then in edge mode.
		wr(PWT_OFS_CFG0, 32'h284, r);
		pwt_pins_inst.drive_ss(1);
		poll("lvl on", PWT_OFS_STATUS, 32'h1, 32'h1);
		pwt_pins_inst.drive_ss(0);
		poll("lvl off", PWT_OFS_STATUS, 32'h1, 32'h0);
		poll("pin stop irq", PWT_OFS_IRQ_STAT, 32'h1, 32'h1);
		wr(PWT_OFS_CFG0, 32'h384, r);
		for (int k = 1; k >= 0; k--) begin
			pwt_pins_inst.drive_ss(1);
			pwt_pins_inst.drive_ss(0);
			poll("edge", PWT_OFS_STATUS, 32'h1, 32'(k));
		end
		// Both controls on pins: firmware run bit is ignored.
		wr(PWT_OFS_CFG0, 32'h684, r);
		wr(PWT_OFS_CTRL, 32'h1, r);
		rd(PWT_OFS_CTRL, d, r); chk("fw blocked", d & 32'h1, 32'h0);
		// PWM start only.
		wr(PWT_OFS_CFG1, 32'h10245, r);
		wr(PWT_OFS_CTRL, 32'h2, r);
		poll("pwm", PWT_OFS_STATUS, 32'h3f, 32'h12);
		chk("pin", timer_output_wave, 32'h2);
		results;
	end
endmodule
`default_nettype wire
